// *** logic/gpio_wake_defines.svh ***
// Register offsets, field positions, reset values and codes of the pin block.
`ifndef GPIO_WAKE_DEFINES_SVH
`define GPIO_WAKE_DEFINES_SVH

// ----------------------------------------------------------------------------
// Pin configuration registers
// ----------------------------------------------------------------------------
`define OFS_CFG_PIN_27 8'h32
`define OFS_CFG_PIN_42 8'h3D
`define OFS_CFG_PIN_50 8'h3F
`define OFS_CFG_PIN_60 8'h47
`define OFS_CFG_PIN_61 8'h48
`define OFS_PIN63_CONFIG 8'h55
`define CFG_DIR_BIT 0
`define CFG_POL_BIT 1
`define CFG_FUNC_LO 2
`define CFG_FUNC_HI 3
`define CFG_DRV_BIT 7
`define CFG_RESET 8'h01
`define FUNC_GPIO 2'h0
`define FUNC_ALT1 2'h1

// ----------------------------------------------------------------------------
// Data registers
// ----------------------------------------------------------------------------
`define OFS_DATA_2 8'h4C
`define OFS_DATA_4 8'h4E
`define OFS_DATA_5 8'h4F
`define OFS_DATA_6 8'h50

// ----------------------------------------------------------------------------
// Wake, SMI, either-edge and LED registers
// ----------------------------------------------------------------------------
`define OFS_WAKE_PIN_STATUS 8'h00
`define OFS_WAKE_PIN_ENABLE 8'h02
`define OFS_WAKE_STATUS_3 8'h06
`define OFS_WAKE_STATUS_5 8'h08
`define OFS_WAKE_STATUS_6 8'h09
`define OFS_WAKE_ENABLE_3 8'h0A
`define OFS_WAKE_ENABLE_5 8'h0C
`define OFS_WAKE_ENABLE_6 8'h0D
`define OFS_SMI_STATUS_1 8'h10
`define OFS_SMI_STATUS_2 8'h11
`define OFS_SMI_STATUS_3 8'h12
`define OFS_SMI_STATUS_4 8'h13
`define OFS_SMI_ENABLE_1 8'h14
`define OFS_SMI_ENABLE_2 8'h15
`define OFS_SMI_ENABLE_3 8'h16
`define OFS_SMI_ENABLE_4 8'h17
`define OFS_EE_SUMMARY 8'h18
`define OFS_EE_TRIGGER 8'h19
`define OFS_LED_ONE 8'h5D
`define OFS_LED_TWO 8'h5E
`define DEVGRP_BIT 3
`define EN2_TO_PIN_BIT 7
`define EN2_TO_IRQ2_BIT 6
`define EN2_TO_WAKE_BIT 5
`define IR_BIT 0

// ----------------------------------------------------------------------------
// LED control and blink timing in edges of the 32 kHz clock
// ----------------------------------------------------------------------------
`define LED_OFF 2'h0
`define LED_BLINK_FAST 2'h1
`define LED_BLINK_SLOW 2'h2
`define LED_ON 2'h3
`define BLINK_FAST_BIT 14
`define BLINK_SLOW_BIT 15

`endif

// *** logic/gpio_wake_pkg.sv ***
// Types shared by the pin block and its users.
package gpio_wake_pkg;

	typedef struct packed {
		logic [11:0] level;
		logic [11:0] enable;
	} pin_drive_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage : gpio_wake_pkg

// *** logic/gpio_wake_smi_led_logic.sv ***
// General-purpose pins with wake, SMI, either-edge and LED logic.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps

module gpio_wake_smi_led_logic (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire gpio_wake_pkg::reg_req_t req_in,
	output logic [7:0] rd_data_out,
	input wire logic [11:0] pin_level_in,
	input wire logic [1:0] fan_tach_in,
	input wire logic [7:0] sio_smi_1_in,
	input wire logic [7:0] sio_smi_2_in,
	input wire logic infrared_event_in,
	input wire logic clk_32k_in,
	output gpio_wake_pkg::pin_drive_t pin_drive_out,
	output logic smi_irq2_out,
	output logic wake_event_out
);
	import gpio_wake_pkg::*;
`include "gpio_wake_defines.svh"

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	// Pin index: 0 is pin 27, 1 is pin 42, 2..9 are pins 50..57,
	// 10 is pin 60 and 11 is pin 61.
	function automatic logic [7:0] cfg_offset(input int idx);
		logic [7:0] ofs;
		if (idx == 0) begin
			ofs = `OFS_CFG_PIN_27;
		end else if (idx == 1) begin
			ofs = `OFS_CFG_PIN_42;
		end else if (idx == 10) begin
			ofs = `OFS_CFG_PIN_60;
		end else if (idx == 11) begin
			ofs = `OFS_CFG_PIN_61;
		end else begin
			ofs = `OFS_CFG_PIN_50 + 8'(idx - 2);
		end
		return ofs;
	endfunction : cfg_offset

	// Sticky bit update; a set in the clear cycle wins.
	function automatic logic [7:0] sticky(input logic [7:0] cur,
		input logic [7:0] set, input logic [7:0] clr);
		return set | (cur & ~clr);
	endfunction : sticky

	// Level driven out of a pin stage for a wanted logic value.
	function automatic logic [1:0] drive(input logic val,
		input logic push_pull);
		logic [1:0] lv_oe;
		lv_oe = push_pull ? {val, 1'b1} : {1'b0, ~val};
		return lv_oe;
	endfunction : drive

	// ------------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------------
	logic [7:0] cfg_q [12];
	logic [11:0] data_q;
	logic [7:0] pin63_cfg_q;
	logic [7:0] led_one_q;
	logic [7:0] led_two_q;
	logic [7:0] wake_status_3_q;
	logic [7:0] wake_status_5_q;
	logic [7:0] wake_status_6_q;
	logic [7:0] wake_enable_3_q;
	logic [7:0] wake_enable_5_q;
	logic [7:0] wake_enable_6_q;
	logic [7:0] wake_pin_status_q;
	logic [7:0] wake_pin_enable_q;
	logic [7:0] smi_status_2_q;
	logic [7:0] smi_status_3_q;
	logic [7:0] smi_status_4_q;
	logic [7:0] smi_enable_1_q;
	logic [7:0] smi_enable_2_q;
	logic [7:0] smi_enable_3_q;
	logic [7:0] smi_enable_4_q;
	logic [7:0] ee_summary_q;
	logic [7:0] either_edge_trigger_q;
	logic [7:0] rd_data_q;
	logic [7:0] rd_data_d;
	logic [11:0] pin_meta_q;
	logic [11:0] pin_sync_q;
	logic [11:0] pin_prev_q;
	logic [1:0] tach_meta_q;
	logic [1:0] tach_sync_q;
	logic [1:0] tach_prev_q;
	logic k32_meta_q;
	logic k32_sync_q;
	logic k32_prev_q;
	logic [15:0] blink_cnt_q;
	pin_drive_t drive_q;
	pin_drive_t drive_d;
	logic smi_irq2_q;
	logic wake_event_q;

	logic wr_hit;
	logic rd_hit;
	logic [11:0] is_input;
	logic [11:0] rise;
	logic [11:0] fall;
	logic [11:0] qual;
	logic [1:0] tach_qual;
	logic [1:0] ee_any;
	logic group_smi;

	assign wr_hit = req_in.wr;
	assign rd_hit = req_in.rd;

	// ------------------------------------------------------------------------
	// Input synchronisers and edge qualification
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pin_meta_q <= 12'h000;
			pin_sync_q <= 12'h000;
			pin_prev_q <= 12'h000;
			tach_meta_q <= 2'h0;
			tach_sync_q <= 2'h0;
			tach_prev_q <= 2'h0;
		end else begin
			pin_meta_q <= pin_level_in;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
			tach_meta_q <= fan_tach_in;
			tach_sync_q <= tach_meta_q;
			tach_prev_q <= tach_sync_q;
		end
	end

	// Edges are taken on the raw synchronised level, so toggling the
	// polarity bit alone never fakes an edge.
	always_comb begin
		for (int i = 0; i < 12; i++) begin
			rise[i] = pin_sync_q[i] & ~pin_prev_q[i];
			fall[i] = ~pin_sync_q[i] & pin_prev_q[i];
			is_input[i] = cfg_q[i][`CFG_DIR_BIT];
			if (i >= 10 && either_edge_trigger_q[i - 10]) begin
				is_input[i] = 1'b1;
				qual[i] = rise[i] | fall[i];
			end else if (cfg_q[i][`CFG_POL_BIT]) begin
				qual[i] = is_input[i] & fall[i];
			end else begin
				qual[i] = is_input[i] & rise[i];
			end
		end
		for (int t = 0; t < 2; t++) begin
			tach_qual[t] = tach_sync_q[t] & ~tach_prev_q[t];
		end
		ee_any = rise[11:10] | fall[11:10];
	end

	// ------------------------------------------------------------------------
	// Configuration, data and LED registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < 12; i++) begin
				cfg_q[i] <= `CFG_RESET;
			end
			pin63_cfg_q <= `CFG_RESET;
			led_one_q <= 8'h00;
			led_two_q <= 8'h00;
			either_edge_trigger_q <= 8'h00;
		end else if (wr_hit) begin
			for (int i = 0; i < 12; i++) begin
				if (req_in.addr == cfg_offset(i)) begin
					cfg_q[i] <= req_in.wdata;
				end
			end
			if (req_in.addr == `OFS_PIN63_CONFIG) begin
				pin63_cfg_q <= req_in.wdata;
			end else if (req_in.addr == `OFS_LED_ONE) begin
				led_one_q <= req_in.wdata;
			end else if (req_in.addr == `OFS_LED_TWO) begin
				led_two_q <= req_in.wdata;
			end else if (req_in.addr == `OFS_EE_TRIGGER) begin
				either_edge_trigger_q <= {6'h00, req_in.wdata[1:0]};
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			data_q <= 12'h000;
		end else if (wr_hit) begin
			// Only output pins accept the written bit.
			if (req_in.addr == `OFS_DATA_2 && !is_input[0]) begin
				data_q[0] <= req_in.wdata[7];
			end else if (req_in.addr == `OFS_DATA_4 && !is_input[1]) begin
				data_q[1] <= req_in.wdata[2];
			end else if (req_in.addr == `OFS_DATA_5) begin
				for (int i = 2; i < 10; i++) begin
					if (!is_input[i]) begin
						data_q[i] <= req_in.wdata[i - 2];
					end
				end
			end else if (req_in.addr == `OFS_DATA_6) begin
				for (int i = 10; i < 12; i++) begin
					if (!is_input[i]) begin
						data_q[i] <= req_in.wdata[i - 10];
					end
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// Status registers
	// ------------------------------------------------------------------------
	logic [7:0] clr_mask [8];
	logic [7:0] w3_set;
	logic [7:0] w5_set;
	logic [7:0] w6_set;
	logic [7:0] s3_set;
	logic [7:0] s4_set;
	logic [7:0] wp_set;

	always_comb begin
		for (int k = 0; k < 8; k++) begin
			clr_mask[k] = 8'h00;
		end
		if (wr_hit) begin
			if (req_in.addr == `OFS_WAKE_STATUS_3) begin
				clr_mask[0] = req_in.wdata;
			end else if (req_in.addr == `OFS_WAKE_STATUS_5) begin
				clr_mask[1] = req_in.wdata;
			end else if (req_in.addr == `OFS_WAKE_STATUS_6) begin
				clr_mask[2] = req_in.wdata;
			end else if (req_in.addr == `OFS_SMI_STATUS_3) begin
				clr_mask[3] = req_in.wdata;
			end else if (req_in.addr == `OFS_SMI_STATUS_4) begin
				clr_mask[4] = req_in.wdata;
			end else if (req_in.addr == `OFS_EE_SUMMARY) begin
				clr_mask[5] = req_in.wdata;
			end else if (req_in.addr == `OFS_WAKE_PIN_STATUS) begin
				clr_mask[6] = req_in.wdata;
			end
		end
		w3_set = 8'h00;
		w3_set[0] = qual[0];
		w3_set[`DEVGRP_BIT] = group_smi & smi_enable_2_q[`EN2_TO_WAKE_BIT];
		w5_set = qual[9:2];
		w6_set = {6'h00, qual[11:10]};
		s3_set = {1'b0, tach_qual, qual[10], qual[9:6]};
		s4_set = {6'h00, qual[11], qual[1]};
		wp_set = 8'h00;
		wp_set[0] = |{wake_status_3_q & wake_enable_3_q,
			wake_status_5_q & wake_enable_5_q,
			wake_status_6_q & wake_enable_6_q};
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wake_status_3_q <= 8'h00;
			wake_status_5_q <= 8'h00;
			wake_status_6_q <= 8'h00;
			smi_status_3_q <= 8'h00;
			smi_status_4_q <= 8'h00;
			ee_summary_q <= 8'h00;
			wake_pin_status_q <= 8'h00;
		end else begin
			wake_status_3_q <= sticky(wake_status_3_q, w3_set, clr_mask[0]);
			wake_status_5_q <= sticky(wake_status_5_q, w5_set, clr_mask[1]);
			wake_status_6_q <= sticky(wake_status_6_q, w6_set, clr_mask[2]);
			smi_status_3_q <= sticky(smi_status_3_q, s3_set, clr_mask[3]);
			smi_status_4_q <= sticky(smi_status_4_q, s4_set, clr_mask[4]);
			ee_summary_q <= sticky(ee_summary_q, {6'h00, ee_any},
				clr_mask[5]);
			wake_pin_status_q <= sticky(wake_pin_status_q, wp_set,
				clr_mask[6]);
		end
	end

	// Group two follows its sources except the infrared bit, which is
	// latched here and dropped by a read of the register.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			smi_status_2_q <= 8'h00;
		end else begin
			smi_status_2_q[7:1] <= sio_smi_2_in[7:1];
			if (infrared_event_in) begin
				smi_status_2_q[`IR_BIT] <= 1'b1;
			end else if (rd_hit && req_in.addr == `OFS_SMI_STATUS_2) begin
				smi_status_2_q[`IR_BIT] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Enable registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wake_enable_3_q <= 8'h00;
			wake_enable_5_q <= 8'h00;
			wake_enable_6_q <= 8'h00;
			wake_pin_enable_q <= 8'h00;
			smi_enable_1_q <= 8'h00;
			smi_enable_2_q <= 8'h00;
			smi_enable_3_q <= 8'h00;
			smi_enable_4_q <= 8'h00;
		end else if (wr_hit) begin
			if (req_in.addr == `OFS_WAKE_ENABLE_3) begin
				wake_enable_3_q <= req_in.wdata;
			end else if (req_in.addr == `OFS_WAKE_ENABLE_5) begin
				wake_enable_5_q <= req_in.wdata;
			end else if (req_in.addr == `OFS_WAKE_ENABLE_6) begin
				wake_enable_6_q <= {6'h00, req_in.wdata[1:0]};
			end else if (req_in.addr == `OFS_WAKE_PIN_ENABLE) begin
				wake_pin_enable_q <= {7'h00, req_in.wdata[0]};
			end else if (req_in.addr == `OFS_SMI_ENABLE_1) begin
				smi_enable_1_q <= req_in.wdata;
			end else if (req_in.addr == `OFS_SMI_ENABLE_2) begin
				smi_enable_2_q <= req_in.wdata;
			end else if (req_in.addr == `OFS_SMI_ENABLE_3) begin
				smi_enable_3_q <= req_in.wdata;
			end else if (req_in.addr == `OFS_SMI_ENABLE_4) begin
				smi_enable_4_q <= {6'h00, req_in.wdata[1:0]};
			end
		end
	end

	// Low five enable-two bits gate group two sources; the top three route.
	assign group_smi = |{sio_smi_1_in & smi_enable_1_q,
		smi_status_2_q[4:0] & smi_enable_2_q[4:0],
		smi_status_3_q & smi_enable_3_q,
		smi_status_4_q & smi_enable_4_q};

	// ------------------------------------------------------------------------
	// LED blink timebase
	// ------------------------------------------------------------------------
	// Blinking only advances on 32 kHz edges; without that clock the LED
	// freezes in its current phase, while steady on and off still work.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			k32_meta_q <= 1'b0;
			k32_sync_q <= 1'b0;
			k32_prev_q <= 1'b0;
			blink_cnt_q <= 16'h0000;
		end else begin
			k32_meta_q <= clk_32k_in;
			k32_sync_q <= k32_meta_q;
			k32_prev_q <= k32_sync_q;
			if (k32_sync_q && !k32_prev_q) begin
				blink_cnt_q <= blink_cnt_q + 16'h0001;
			end
		end
	end

	function automatic logic led_lit(input logic [1:0] mode,
		input logic [15:0] cnt);
		logic lit;
		case (mode)
			`LED_ON: lit = 1'b1;
			`LED_BLINK_FAST: lit = cnt[`BLINK_FAST_BIT];
			`LED_BLINK_SLOW: lit = cnt[`BLINK_SLOW_BIT];
			default: lit = 1'b0;
		endcase
		return lit;
	endfunction : led_lit

	// ------------------------------------------------------------------------
	// Pin output stages
	// ------------------------------------------------------------------------
	always_comb begin
		logic val;
		logic pp;
		logic [1:0] func;
		logic [1:0] lv_oe;
		val = 1'b0;
		pp = 1'b0;
		func = 2'h0;
		lv_oe = 2'h0;
		drive_d = '0;
		for (int i = 0; i < 12; i++) begin
			func = cfg_q[i][`CFG_FUNC_HI:`CFG_FUNC_LO];
			pp = cfg_q[i][`CFG_DRV_BIT];
			val = data_q[i] ^ cfg_q[i][`CFG_POL_BIT];
			lv_oe = 2'h0;
			if (i == 0 && func == `FUNC_ALT1) begin
				// Active low when polarity is clear.
				val = ~(group_smi & smi_enable_2_q[`EN2_TO_PIN_BIT]) ^
					cfg_q[i][`CFG_POL_BIT];
				lv_oe = drive(val, pp);
			end else if (i == 1 && func == `FUNC_ALT1) begin
				val = ~(wake_pin_status_q[0] & wake_pin_enable_q[0]) ^
					cfg_q[i][`CFG_POL_BIT];
				lv_oe = drive(val, pp);
			end else if (i >= 10 && func == `FUNC_ALT1) begin
				val = ~led_lit(i == 10 ? led_one_q[1:0] : led_two_q[1:0],
					blink_cnt_q);
				lv_oe = drive(val, pp);
			end else if (!is_input[i]) begin
				lv_oe = drive(val, pp);
			end
			drive_d.level[i] = lv_oe[1];
			drive_d.enable[i] = lv_oe[0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			drive_q <= '0;
			smi_irq2_q <= 1'b0;
			wake_event_q <= 1'b0;
		end else begin
			drive_q <= drive_d;
			smi_irq2_q <= group_smi & smi_enable_2_q[`EN2_TO_IRQ2_BIT];
			wake_event_q <= wake_pin_status_q[0] & wake_pin_enable_q[0];
		end
	end

	// ------------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------------
	logic [11:0] data_view;

	always_comb begin
		rd_data_d = 8'h00;
		for (int i = 0; i < 12; i++) begin
			// Inputs show the sampled pin, outputs the stored bit.
			data_view[i] = is_input[i] ?
				pin_sync_q[i] ^ cfg_q[i][`CFG_POL_BIT] : data_q[i];
			if (req_in.addr == cfg_offset(i)) begin
				rd_data_d = cfg_q[i];
			end
		end
		if (req_in.addr == `OFS_DATA_2) begin
			rd_data_d = {data_view[0], 7'h00};
		end else if (req_in.addr == `OFS_DATA_4) begin
			rd_data_d = {5'h00, data_view[1], 2'h0};
		end else if (req_in.addr == `OFS_DATA_5) begin
			rd_data_d = data_view[9:2];
		end else if (req_in.addr == `OFS_DATA_6) begin
			rd_data_d = {6'h00, data_view[11:10]};
		end else if (req_in.addr == `OFS_PIN63_CONFIG) begin
			rd_data_d = pin63_cfg_q;
		end else if (req_in.addr == `OFS_LED_ONE) begin
			rd_data_d = led_one_q;
		end else if (req_in.addr == `OFS_LED_TWO) begin
			rd_data_d = led_two_q;
		end else if (req_in.addr == `OFS_WAKE_PIN_STATUS) begin
			rd_data_d = wake_pin_status_q;
		end else if (req_in.addr == `OFS_WAKE_PIN_ENABLE) begin
			rd_data_d = wake_pin_enable_q;
		end else if (req_in.addr == `OFS_WAKE_STATUS_3) begin
			rd_data_d = wake_status_3_q;
		end else if (req_in.addr == `OFS_WAKE_STATUS_5) begin
			rd_data_d = wake_status_5_q;
		end else if (req_in.addr == `OFS_WAKE_STATUS_6) begin
			rd_data_d = wake_status_6_q;
		end else if (req_in.addr == `OFS_WAKE_ENABLE_3) begin
			rd_data_d = wake_enable_3_q;
		end else if (req_in.addr == `OFS_WAKE_ENABLE_5) begin
			rd_data_d = wake_enable_5_q;
		end else if (req_in.addr == `OFS_WAKE_ENABLE_6) begin
			rd_data_d = wake_enable_6_q;
		end else if (req_in.addr == `OFS_SMI_STATUS_1) begin
			rd_data_d = sio_smi_1_in;
		end else if (req_in.addr == `OFS_SMI_STATUS_2) begin
			rd_data_d = smi_status_2_q;
		end else if (req_in.addr == `OFS_SMI_STATUS_3) begin
			rd_data_d = smi_status_3_q;
		end else if (req_in.addr == `OFS_SMI_STATUS_4) begin
			rd_data_d = smi_status_4_q;
		end else if (req_in.addr == `OFS_SMI_ENABLE_1) begin
			rd_data_d = smi_enable_1_q;
		end else if (req_in.addr == `OFS_SMI_ENABLE_2) begin
			rd_data_d = smi_enable_2_q;
		end else if (req_in.addr == `OFS_SMI_ENABLE_3) begin
			rd_data_d = smi_enable_3_q;
		end else if (req_in.addr == `OFS_SMI_ENABLE_4) begin
			rd_data_d = smi_enable_4_q;
		end else if (req_in.addr == `OFS_EE_SUMMARY) begin
			rd_data_d = ee_summary_q;
		end else if (req_in.addr == `OFS_EE_TRIGGER) begin
			rd_data_d = either_edge_trigger_q;
		end
	end

	// Read data stand for one cycle only and are zero otherwise.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rd_data_q <= 8'h00;
		end else begin
			rd_data_q <= rd_hit ? rd_data_d : 8'h00;
		end
	end

	assign rd_data_out = rd_data_q;
	assign pin_drive_out = drive_q;
	assign smi_irq2_out = smi_irq2_q;
	assign wake_event_out = wake_event_q;

endmodule : gpio_wake_smi_led_logic

// *** bench/gpio_wake_smi_led_logic_chk.sv ***
// Port assertions for the pin block.
`timescale 1ns/1ps
`include "gpio_wake_defines.svh"
module gpio_wake_smi_led_logic_chk (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire gpio_wake_pkg::reg_req_t req_in,
	input wire logic [7:0] rd_data_out,
	input wire gpio_wake_pkg::pin_drive_t pin_drive_out,
	input wire logic smi_irq2_out,
	input wire logic wake_event_out
);
	import gpio_wake_pkg::*;
	logic [7:0] cfg_q;
	logic dat_q, irq_q, wen_q, oen;
	assign oen = !cfg_q[0] && cfg_q[3:2] == 2'h0;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Shadows of pin 50 and the output gates; input-pin data is dropped.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cfg_q <= `CFG_RESET;
			dat_q <= 1'b0;
			irq_q <= 1'b0;
			wen_q <= 1'b0;
		end else if (req_in.wr) begin
			if (req_in.addr == `OFS_CFG_PIN_50) cfg_q <= req_in.wdata;
			if (req_in.addr == `OFS_DATA_5 && oen) dat_q <= req_in.wdata[0];
			if (req_in.addr == `OFS_SMI_ENABLE_2) irq_q <= req_in.wdata[6];
			if (req_in.addr == `OFS_WAKE_PIN_ENABLE) wen_q <= req_in.wdata[0];
		end
	end
	AST_RD_IDLE: assert property (!req_in.rd |=> rd_data_out == 8'h00)
		else $error("read data outside read slot");
	AST_UNMAPPED: assert property (req_in.rd && req_in.addr == 8'hFF
		|=> rd_data_out == 8'h00) else $error("unmapped read not zero");
	AST_READBACK: assert property (req_in.rd &&
		req_in.addr == `OFS_DATA_5 && oen |=> rd_data_out[0] == $past(dat_q))
		else $error("output readback wrong");
	AST_IN_HIZ: assert property ((cfg_q[0] && cfg_q[3:2] == 2'h0) [*2]
		|=> !pin_drive_out.enable[2]) else $error("input pin driven");
	property drv_p(logic pp);
		(oen && cfg_q[7] == pp && $stable(cfg_q) && $stable(dat_q)) [*2] |=>
		pin_drive_out.level[2] == (pp & ($past(dat_q) ^ $past(cfg_q[1]))) &&
		pin_drive_out.enable[2] == (pp | !($past(dat_q) ^ $past(cfg_q[1])));
	endproperty
	AST_PUSH_PULL: assert property (drv_p(1'b1))
		else $error("push-pull drive wrong");
	AST_OPEN_DRAIN: assert property (drv_p(1'b0))
		else $error("open-drain drive wrong");
	AST_IRQ2_GATE: assert property (!irq_q [*2] |=> !smi_irq2_out)
		else $error("irq2 without enable");
	AST_WAKE_GATE: assert property (!wen_q [*2] |=> !wake_event_out)
		else $error("wake without enable");
	cover property (smi_irq2_out);
	cover property (wake_event_out);
	cover property (oen && pin_drive_out.enable[2]);
endmodule : gpio_wake_smi_led_logic_chk

// *** bench/board_pins_model.sv ***
// Board-side model of the pin levels the block sees.
`timescale 1ns/1ps
module board_pins_model (
	input wire gpio_wake_pkg::pin_drive_t drive_in,
	input wire logic [11:0] ext_in,
	output logic [11:0] level_out
);
	import gpio_wake_pkg::*;
	// The block's own driver wins; elsewhere the board source sets it.
	assign level_out = (drive_in.enable & drive_in.level) |
		(~drive_in.enable & ext_in);
endmodule : board_pins_model

// *** bench/gpio_wake_smi_led_logic_tb.sv ***
// Self-checking bench for the pin block.
`timescale 1ns/1ps
`include "gpio_wake_defines.svh"
module gpio_wake_smi_led_logic_tb;
	import gpio_wake_pkg::*;
	logic clk_in, rst_n_in, k32, irq2, wake, ir;
	reg_req_t req;
	logic [7:0] rd_data, v;
	logic [11:0] ext, pins;
	pin_drive_t drv;
	int errors, n_tests, seed, dm;
	gpio_wake_smi_led_logic DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.req_in(req), .rd_data_out(rd_data), .pin_level_in(pins),
		.fan_tach_in(2'h0), .sio_smi_1_in(8'h00), .sio_smi_2_in(8'h00),
		.infrared_event_in(ir), .clk_32k_in(k32), .pin_drive_out(drv),
		.smi_irq2_out(irq2), .wake_event_out(wake));
	board_pins_model board (.drive_in(drv), .ext_in(ext), .level_out(pins));
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	always @(posedge clk_in) k32 <= ~k32;
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_in);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		@(posedge clk_in);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_in);
		req.rd <= 1'b0;
		#1 v = rd_data;
		chk(v & m, e);
	endtask : rchk
	task automatic settle;
		repeat (5) @(posedge clk_in);
		#1;
	endtask : settle
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	initial begin
		#(20 * 20000);
		errors++;
		close_out;
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		seed = 32'hB7B6;
		req = '0;
		ext = '0;
		k32 = 1'b0;
		ir = 1'b0;
		rst_n_in = 1'b0;
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rchk(`OFS_CFG_PIN_50, 8'hFF, `CFG_RESET);
		rchk(8'hFF, 8'hFF, 8'h00);
		dm = $random(seed);
		wr(`OFS_PIN63_CONFIG, dm[7:0]);
		rchk(`OFS_PIN63_CONFIG, 8'hFF, dm[7:0]);
		for (int i = 0; i < 4; i++) begin
			dm = $random(seed);
			dm[0] = i[1];
			wr(`OFS_CFG_PIN_50, {i[1], 5'h00, i[0], 1'b0});
			wr(`OFS_DATA_5, dm[7:0]);
			settle;
			rchk(`OFS_DATA_5, 8'h01, {7'h00, dm[0]});
			chk(drv.enable[2], i[1] | !(dm[0] ^ i[0]));
			chk(drv.level[2], i[1] & (dm[0] ^ i[0]));
			chk(drv.enable[9:3], 7'h00);
		end
		rchk(`OFS_WAKE_STATUS_5, 8'h01, 8'h00);
		$display("output test done");
		for (int p = 0; p < 2; p++) begin
			dm = $random(seed);
			wr(`OFS_CFG_PIN_50, {6'h00, p[0], 1'b1});
			ext <= {dm[11:3], p[0], dm[1:0]};
			settle;
			wr(`OFS_DATA_5, 8'hFF);
			wr(`OFS_WAKE_STATUS_5, 8'hFF);
			settle;
			chk(drv.enable[9:2], 8'h00);
			rchk(`OFS_DATA_5, 8'hFF, {ext[9:3], 1'b0});
			rchk(`OFS_WAKE_STATUS_5, 8'hFF, 8'h00);
			ext[2] <= ~p[0];
			settle;
			rchk(`OFS_WAKE_STATUS_5, 8'h01, 8'h01);
			wr(`OFS_WAKE_STATUS_5, 8'h01);
			ext[2] <= p[0];
			settle;
			rchk(`OFS_WAKE_STATUS_5, 8'h01, 8'h00);
		end
		$display("input test done");
		wr(`OFS_EE_TRIGGER, 8'h01);
		wr(`OFS_CFG_PIN_60, 8'h82);
		for (int e = 0; e < 2; e++) begin
			wr(`OFS_WAKE_STATUS_6, 8'hFF);
			wr(`OFS_SMI_STATUS_3, 8'hFF);
			wr(`OFS_EE_SUMMARY, 8'hFF);
			ext[10] <= ~ext[10];
			settle;
			rchk(`OFS_WAKE_STATUS_6, 8'h01, 8'h01);
			rchk(`OFS_SMI_STATUS_3, 8'h10, 8'h10);
			rchk(`OFS_EE_SUMMARY, 8'hFF, 8'h01);
			chk(v != 8'h00, 1'b1);
			chk(drv.enable[10], 1'b0);
			rchk(`OFS_DATA_6, 8'h01, {7'h00, ~ext[10]});
		end
		wr(`OFS_EE_TRIGGER, 8'h00);
		$display("either-edge test done");
		ext[6] <= 1'b0;
		settle;
		wr(`OFS_SMI_STATUS_3, 8'hFF);
		wr(`OFS_SMI_ENABLE_3, 8'h01);
		wr(`OFS_SMI_ENABLE_2, 8'h60);
		wr(`OFS_WAKE_ENABLE_3, 8'h08);
		wr(`OFS_WAKE_PIN_ENABLE, 8'h01);
		ext[6] <= 1'b1;
		settle;
		chk(irq2, 1'b1);
		rchk(`OFS_WAKE_STATUS_3, 8'h08, 8'h08);
		chk(wake, 1'b1);
		wr(`OFS_SMI_STATUS_3, 8'h01);
		settle;
		chk(irq2, 1'b0);
		@(posedge clk_in);
		ir <= 1'b1;
		@(posedge clk_in);
		ir <= 1'b0;
		settle;
		rchk(`OFS_SMI_STATUS_2, 8'h01, 8'h01);
		rchk(`OFS_SMI_STATUS_2, 8'h01, 8'h00);
		$display("smi test done");
		wr(`OFS_CFG_PIN_61, 8'h84);
		for (int l = 0; l < 4; l += 3) begin
			wr(`OFS_LED_TWO, l[7:0]);
			settle;
			chk({drv.enable[11], drv.level[11]}, {1'b1, l == 0});
		end
		$display("led test done");
		close_out;
	end
endmodule : gpio_wake_smi_led_logic_tb
bind gpio_wake_smi_led_logic gpio_wake_smi_led_logic_chk chk (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req_in),
	.rd_data_out(rd_data_out), .pin_drive_out(pin_drive_out),
	.smi_irq2_out(smi_irq2_out), .wake_event_out(wake_event_out));
